// ==== core/gpc_out_select.sv ====
// Output function selector for one general-purpose pin.
`timescale 1ns/10ps
`default_nettype none
`include "gpc_consts.svh"

module gpc_out_select (
    input wire gpc_pkg::gpc_byte_type ctl_i,
    input wire logic [7:0] rx_fwd_gpio_i,
    input wire logic [1:0] rx_lock_i,
    input wire logic [1:0] rx_pass_i,
    input wire logic [1:0] rx_frame_valid_i,
    input wire logic [1:0] rx_line_valid_i,
    input wire logic [1:0] rx_port_enable_i,
    input wire logic frame_sync_i,
    input wire logic device_irq_i,
    output logic drive_level_o,
    output logic drive_enable_o
);
    import gpc_pkg::*;

    logic [2:0] func;
    logic [2:0] src;
    logic port;

    assign func = ctl_i[`GPC_CTL_FUNC_MSB:`GPC_CTL_FUNC_LSB];
    assign src = ctl_i[`GPC_CTL_SRC_MSB:`GPC_CTL_SRC_LSB];
    assign port = src[0];
    // When the enable bit is clear the pin is left undriven, except the open-drain pin 3 while an interrupt is pending.
    assign drive_enable_o = ctl_i[`GPC_CTL_EN_BIT];

    always_comb begin
        drive_level_o = 1'b0;
        case (src)
            GPC_SRC_RX0, GPC_SRC_RX1: begin
                // Both receive ports share one decode; the low source bit picks the port.
                case (func)
                    3'b000, 3'b001, 3'b010, 3'b011: begin
                        drive_level_o = rx_fwd_gpio_i[{port, func[1:0]}];
                    end
                    3'b100: begin
                        drive_level_o = rx_lock_i[port];
                    end
                    3'b101: begin
                        drive_level_o = rx_pass_i[port];
                    end
                    3'b110: begin
                        drive_level_o = rx_frame_valid_i[port];
                    end
                    default: begin
                        drive_level_o = rx_line_valid_i[port];
                    end
                endcase
            end
            GPC_SRC_DEV: begin
                case (func)
                    GPC_DEV_REG_VALUE: begin
                        drive_level_o = ctl_i[`GPC_CTL_VAL_BIT];
                    end
                    GPC_DEV_LOCK_OR: begin
                        drive_level_o = |(rx_lock_i & rx_port_enable_i);
                    end
                    GPC_DEV_LOCK_AND: begin
                        drive_level_o = (|rx_port_enable_i) && (&(rx_lock_i | ~rx_port_enable_i));
                    end
                    GPC_DEV_PASS_AND: begin
                        drive_level_o = (|rx_port_enable_i) && (&(rx_pass_i | ~rx_port_enable_i));
                    end
                    GPC_DEV_FRAME_SYNC: begin
                        drive_level_o = frame_sync_i;
                    end
                    GPC_DEV_IRQ_HIGH: begin
                        drive_level_o = device_irq_i;
                    end
                    GPC_DEV_IRQ_LOW: begin
                        drive_level_o = ~device_irq_i;
                    end
                    default: begin
                        drive_level_o = 1'b0;
                    end
                endcase
            end
            default: begin
                // Reserved and unsupported source groups drive low rather than float unknown.
                drive_level_o = 1'b0;
            end
        endcase
    end

endmodule
`default_nettype wire

// ==== core/gpc_pin_control.sv ====
// General-purpose pin block: control registers, pin drivers and level readback.
//
// Overview of operation
// - Seven pins, 0 to 6, handled through byte registers 0x0E to 0x16 and 0xBE.
// - Pin 3 is open drain, shared with interrupt, only pulls low.
// - After reset every pin is input, input path and pulldown enabled.
// - Each pin but 3 has own input-disable and pulldown-disable bits.
// - Input control bit n disables pin n input when set.
// - Level readback register returns every pin level, input or output.
// - Control byte: function 7:5, source 4:2, value 1, enable 0.
// - Source 000, functions 000 to 011 give port 0 forwarded states.
// - Source 000, function 100 gives port 0 lock, 101 pass.
// - Source 000, function 110 gives frame valid, 111 line valid.
// - Source 001 gives the same selections taken from receive port 1.
// - Source 100 function 000 drives the register value bit.
`timescale 1ns/10ps
`default_nettype none
`include "gpc_consts.svh"

module gpc_pin_control #(
    parameter int PIN_COUNT = `GPC_PIN_COUNT,
    parameter int OPEN_DRAIN_PIN = `GPC_OPEN_DRAIN_PIN
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire gpc_pkg::gpc_byte_type reg_addr_i,
    input wire logic reg_wr_i,
    input wire gpc_pkg::gpc_byte_type reg_wdata_i,
    input wire logic reg_rd_i,
    output gpc_pkg::gpc_byte_type reg_rdata_o,
    input wire logic [PIN_COUNT-1:0] pin_in_i,
    output logic [PIN_COUNT-1:0] pin_out_o,
    output logic [PIN_COUNT-1:0] pin_oe_o,
    output logic [PIN_COUNT-1:0] pin_input_en_o,
    output logic [PIN_COUNT-1:0] pin_pulldown_en_o,
    input wire logic [7:0] rx_fwd_gpio_i,
    input wire logic [1:0] rx_lock_i,
    input wire logic [1:0] rx_pass_i,
    input wire logic [1:0] rx_frame_valid_i,
    input wire logic [1:0] rx_line_valid_i,
    input wire logic [1:0] rx_port_enable_i,
    input wire logic frame_sync_i,
    input wire logic device_irq_i
);
    import gpc_pkg::*;

    // Byte registers hold at most seven pins plus the unused top bit, so larger counts are refused.
    if (PIN_COUNT < 1 || PIN_COUNT > 7 || OPEN_DRAIN_PIN < 0
            || OPEN_DRAIN_PIN >= PIN_COUNT) begin : gen_bad_params
        $error("gpc_pin_control: unsupported pin count or open-drain index");
    end

    // Bits that exist in the per-pin input and pulldown registers; the open-drain pin has none.
    localparam logic [7:0] PIN_BITS =
        8'(((1 << PIN_COUNT) - 1) & ~(1 << OPEN_DRAIN_PIN));

    gpc_byte_type input_dis;
    gpc_byte_type pulldown_dis;
    gpc_byte_type ctl [PIN_COUNT];
    gpc_byte_type rdata;
    logic [PIN_COUNT-1:0] drive_out;
    logic [PIN_COUNT-1:0] drive_oe;

    gpc_byte_type next_input_dis;
    gpc_byte_type next_pulldown_dis;
    gpc_byte_type next_ctl [PIN_COUNT];
    gpc_byte_type next_rdata;
    logic [PIN_COUNT-1:0] next_drive_out;
    logic [PIN_COUNT-1:0] next_drive_oe;

    logic [PIN_COUNT-1:0] sel_level;
    logic [PIN_COUNT-1:0] sel_enable;

    function automatic logic is_ctl_addr(input gpc_byte_type addr, input int idx);
        return addr == 8'(`GPC_OFS_CTL_FIRST + idx);
    endfunction

    // Register file: writes and registered read data.
    always_comb begin
        next_input_dis = input_dis;
        next_pulldown_dis = pulldown_dis;
        for (int i = 0; i < PIN_COUNT; i++) begin
            next_ctl[i] = ctl[i];
        end
        next_rdata = rdata;
        if (reg_wr_i) begin
            if (reg_addr_i == `GPC_OFS_INPUT_DIS) begin
                next_input_dis = reg_wdata_i & PIN_BITS;
            end
            if (reg_addr_i == `GPC_OFS_PULLDOWN_DIS) begin
                next_pulldown_dis = reg_wdata_i & PIN_BITS;
            end
            for (int i = 0; i < PIN_COUNT; i++) begin
                if (is_ctl_addr(reg_addr_i, i)) begin
                    next_ctl[i] = reg_wdata_i;
                end
            end
        end
        if (reg_rd_i) begin
            next_rdata = `GPC_UNMAPPED_READ;
            if (reg_addr_i == `GPC_OFS_PIN_LEVEL) begin
                // The pad level is returned regardless of direction, so a driven pin reads back.
                next_rdata = 8'(pin_in_i);
            end
            if (reg_addr_i == `GPC_OFS_INPUT_DIS) begin
                next_rdata = input_dis;
            end
            if (reg_addr_i == `GPC_OFS_PULLDOWN_DIS) begin
                next_rdata = pulldown_dis;
            end
            for (int i = 0; i < PIN_COUNT; i++) begin
                if (is_ctl_addr(reg_addr_i, i)) begin
                    next_rdata = ctl[i];
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            input_dis <= `GPC_RST_INPUT_DIS;
            pulldown_dis <= `GPC_RST_PULLDOWN_DIS;
            for (int i = 0; i < PIN_COUNT; i++) begin
                ctl[i] <= `GPC_RST_CTL;
            end
            rdata <= `GPC_UNMAPPED_READ;
        end else begin
            input_dis <= next_input_dis;
            pulldown_dis <= next_pulldown_dis;
            for (int i = 0; i < PIN_COUNT; i++) begin
                ctl[i] <= next_ctl[i];
            end
            rdata <= next_rdata;
        end
    end

    assign reg_rdata_o = rdata;

    generate
        for (genvar g = 0; g < PIN_COUNT; g++) begin : gen_sel
            gpc_out_select u_sel (
                .ctl_i(ctl[g]),
                .rx_fwd_gpio_i(rx_fwd_gpio_i),
                .rx_lock_i(rx_lock_i),
                .rx_pass_i(rx_pass_i),
                .rx_frame_valid_i(rx_frame_valid_i),
                .rx_line_valid_i(rx_line_valid_i),
                .rx_port_enable_i(rx_port_enable_i),
                .frame_sync_i(frame_sync_i),
                .device_irq_i(device_irq_i),
                .drive_level_o(sel_level[g]),
                .drive_enable_o(sel_enable[g])
            );
        end
    endgenerate

    // Pin drivers are registered once, so a register write shows at the pad one cycle later.
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (i == OPEN_DRAIN_PIN) begin
                // Never drives high; pulls low for a selected low level or a pending interrupt.
                next_drive_out[i] = 1'b0;
                next_drive_oe[i] = (sel_enable[i] && !sel_level[i]) || device_irq_i;
            end else begin
                next_drive_out[i] = sel_level[i];
                next_drive_oe[i] = sel_enable[i];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            drive_out <= '0;
            drive_oe <= '0;
        end else begin
            drive_out <= next_drive_out;
            drive_oe <= next_drive_oe;
        end
    end

    assign pin_out_o = drive_out;
    assign pin_oe_o = drive_oe;
    // Input and pulldown enables follow their registers directly; they are static pad settings.
    assign pin_input_en_o = ~input_dis[PIN_COUNT-1:0];
    assign pin_pulldown_en_o = ~pulldown_dis[PIN_COUNT-1:0];

endmodule
`default_nettype wire

// ==== shared/gpc_consts.svh ====
// Offsets, field positions and reset values of the general-purpose pin block.
`ifndef GPC_CONSTS_SVH
`define GPC_CONSTS_SVH

`define GPC_PIN_COUNT 7
`define GPC_OPEN_DRAIN_PIN 3
`define GPC_OFS_PIN_LEVEL 8'h0E
`define GPC_OFS_INPUT_DIS 8'h0F
`define GPC_OFS_CTL_FIRST 8'h10
`define GPC_OFS_CTL_LAST 8'h16
`define GPC_OFS_PULLDOWN_DIS 8'hBE

`define GPC_CTL_FUNC_MSB 7
`define GPC_CTL_FUNC_LSB 5
`define GPC_CTL_SRC_MSB 4
`define GPC_CTL_SRC_LSB 2
`define GPC_CTL_VAL_BIT 1
`define GPC_CTL_EN_BIT 0

`define GPC_RST_INPUT_DIS 8'h00
`define GPC_RST_PULLDOWN_DIS 8'h00
`define GPC_RST_CTL 8'h00
`define GPC_UNMAPPED_READ 8'h00

`endif

// ==== shared/gpc_pkg.sv ====
// Types shared by the general-purpose pin block.
package gpc_pkg;

    typedef logic [7:0] gpc_byte_type;

    typedef enum logic [2:0] {
        GPC_SRC_RX0 = 3'b000,
        GPC_SRC_RX1 = 3'b001,
        GPC_SRC_DEV = 3'b100
    } gpc_src_type;

    typedef enum logic [2:0] {
        GPC_DEV_REG_VALUE = 3'b000,
        GPC_DEV_LOCK_OR = 3'b001,
        GPC_DEV_LOCK_AND = 3'b010,
        GPC_DEV_PASS_AND = 3'b011,
        GPC_DEV_FRAME_SYNC = 3'b100,
        GPC_DEV_IRQ_HIGH = 3'b101,
        GPC_DEV_IRQ_LOW = 3'b110
    } gpc_dev_func_type;

endpackage

// ==== sim/gpc_board_model.sv ====
// Board side of the seven pads: outside drivers, pulls and the interrupt pull-up.
`timescale 1ns/10ps
`default_nettype none
module gpc_board_model (
    input wire logic clk_sys_i,
    input wire logic [6:0] pin_out_i,
    input wire logic [6:0] pin_oe_i,
    input wire logic [6:0] pulldown_en_i,
    input wire logic [6:0] drv_en_i,
    input wire logic [6:0] drv_val_i,
    output logic [6:0] level_o
);
    logic [6:0] floating = 7'h55;
    // An undriven, unpulled pad must not look stable, so it toggles every cycle.
    always_ff @(posedge clk_sys_i) begin
        floating <= ~floating;
    end
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            if (i == 3)
                level_o[i] = !pin_oe_i[i];
            else if (pin_oe_i[i])
                level_o[i] = pin_out_i[i];
            else if (drv_en_i[i])
                level_o[i] = drv_val_i[i];
            else if (pulldown_en_i[i])
                level_o[i] = 1'b0;
            else
                level_o[i] = floating[i];
        end
    end
endmodule
`default_nettype wire

// ==== sim/gpc_pin_control_chk.sv ====
// Port checker for the general-purpose pin block.
`timescale 1ns/10ps
`default_nettype none
module gpc_pin_control_chk #(
    parameter int PIN_COUNT = 7
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire gpc_pkg::gpc_byte_type reg_addr_i,
    input wire logic reg_wr_i,
    input wire gpc_pkg::gpc_byte_type reg_wdata_i,
    input wire logic reg_rd_i,
    input wire gpc_pkg::gpc_byte_type reg_rdata_o,
    input wire logic [PIN_COUNT-1:0] pin_in_i,
    input wire logic [PIN_COUNT-1:0] pin_out_o,
    input wire logic [PIN_COUNT-1:0] pin_oe_o,
    input wire logic [PIN_COUNT-1:0] pin_input_en_o,
    input wire logic [PIN_COUNT-1:0] pin_pulldown_en_o,
    input wire logic [7:0] rx_fwd_gpio_i
);
    import gpc_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    property p_od_low;
        pin_out_o[3] == 1'b0;
    endproperty
    a_od_low: assert property (p_od_low)
        else $error("pin 3 driven high");
    property p_fixed3;
        pin_input_en_o[3] && pin_pulldown_en_o[3];
    endproperty
    a_fixed3: assert property (p_fixed3)
        else $error("pin 3 controls moved");
    property p_rst;
        $rose(rstn_i) |-> &pin_input_en_o && &pin_pulldown_en_o && pin_oe_o[2:0] == 3'h0;
    endproperty
    a_rst: assert property (p_rst)
        else $error("pins not inputs after reset");
    property p_in_dis;
        reg_wr_i && reg_addr_i == 8'h0F
            |-> ##[1:2] pin_input_en_o[2:0] == ~$past(reg_wdata_i[2:0]);
    endproperty
    a_in_dis: assert property (p_in_dis)
        else $error("input disable not applied");
    property p_pd_dis;
        reg_wr_i && reg_addr_i == 8'hBE
            |-> ##[1:2] pin_pulldown_en_o[6:4] == ~$past(reg_wdata_i[6:4]);
    endproperty
    a_pd_dis: assert property (p_pd_dis)
        else $error("pulldown disable not applied");
    property p_level;
        reg_rd_i && reg_addr_i == 8'h0E |=> reg_rdata_o == {1'b0, $past(pin_in_i)};
    endproperty
    a_level: assert property (p_level)
        else $error("level readback wrong");
    property p_fwd0;
        reg_wr_i && reg_addr_i == 8'h10 && reg_wdata_i == 8'h01 ##1 !reg_wr_i
            |=> pin_oe_o[0] && pin_out_o[0] == $past(rx_fwd_gpio_i[0]);
    endproperty
    a_fwd0: assert property (p_fwd0)
        else $error("forwarded state not on pin 0");
    property p_off;
        reg_wr_i && reg_addr_i == 8'h10 && !reg_wdata_i[0] ##1 !reg_wr_i |=> !pin_oe_o[0];
    endproperty
    a_off: assert property (p_off)
        else $error("pin 0 driven while disabled");
    property p_val;
        reg_wr_i && reg_addr_i == 8'h16 && reg_wdata_i[7:2] == 6'h04 && reg_wdata_i[0]
            ##1 !reg_wr_i
            |=> pin_oe_o[6] && pin_out_o[6] == $past(reg_wdata_i[1], 2);
    endproperty
    a_val: assert property (p_val)
        else $error("pin 6 value bit not driven");
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking testbench for the general-purpose pin block.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import gpc_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic irq = 1'b0;
    logic fsync = 1'b0;
    gpc_byte_type reg_addr = 8'h00;
    gpc_byte_type reg_wdata = 8'h00;
    gpc_byte_type rdata;
    logic [7:0] fwd = 8'h00;
    logic [1:0] lock = 2'h0, pass = 2'h0, fv = 2'h0, lv = 2'h0, pen = 2'h3;
    logic [6:0] pin_lvl, pin_out, pin_oe, in_en, pd_en;
    logic [6:0] drv_en = 7'h00, drv_val = 7'h00;
    int num_errors = 0, comparisons = 0, cycles = 0;
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    gpc_pin_control i_gpc_pin_control (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd),
        .reg_rdata_o(rdata), .pin_in_i(pin_lvl), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
        .pin_input_en_o(in_en), .pin_pulldown_en_o(pd_en), .rx_fwd_gpio_i(fwd),
        .rx_lock_i(lock), .rx_pass_i(pass), .rx_frame_valid_i(fv), .rx_line_valid_i(lv),
        .rx_port_enable_i(pen), .frame_sync_i(fsync), .device_irq_i(irq));
    gpc_board_model i_gpc_board_model (.clk_sys_i(clk_sys_i), .pin_out_i(pin_out),
        .pin_oe_i(pin_oe), .pulldown_en_i(pd_en), .drv_en_i(drv_en), .drv_val_i(drv_val),
        .level_o(pin_lvl));
    task automatic end_sim;
        $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input gpc_byte_type a, input gpc_byte_type d);
        @(posedge clk_sys_i);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(input gpc_byte_type a, input gpc_byte_type exp);
        @(posedge clk_sys_i);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd <= 1'b0;
        #1 check(rdata, exp);
    endtask
    task automatic settle;
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask
    // Expected pin level for a control byte of the port groups or the value bit.
    function automatic logic exp_out(input gpc_byte_type c);
        logic p;
        p = c[2];
        if (c[4:2] == 3'b100)
            return c[1];
        case (c[7:5])
            3'd4: return lock[p];
            3'd5: return pass[p];
            3'd6: return fv[p];
            3'd7: return lv[p];
            default: return fwd[{p, c[6:5]}];
        endcase
    endfunction
    // Expected pin level for the device status group, function code f.
    function automatic logic exp_dev(input logic [2:0] f);
        case (f)
            3'h1: return (lock & pen) != 2'h0;
            3'h2: return (pen != 2'h0) && ((lock & pen) == pen);
            3'h3: return (pen != 2'h0) && ((pass & pen) == pen);
            3'h4: return fsync;
            3'h5: return irq;
            3'h6: return !irq;
            default: return 1'b0;
        endcase
    endfunction
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        gpc_byte_type d;
        int p;
        void'($urandom(32'hbedf));
        repeat (8) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        @(posedge clk_sys_i);
        #1 check({in_en, pd_en[0]}, 8'hFF);
        check({1'b0, pd_en}, 8'h7F);
        check({1'b0, pin_oe}, 8'h00);
        for (int a = 8'h0F; a <= 8'h16; a++)
            rdc(a[7:0], 8'h00);
        rdc(8'hBE, 8'h00);
        wr(8'h0E, 8'hFF);
        rdc(8'h0E, {1'b0, pin_lvl});
        rdc(8'h20, 8'h00);
        $display("reset defaults done");
        wr(8'h0F, 8'h06);
        settle();
        check({1'b0, in_en}, 8'h79);
        repeat (6) begin
            d = 8'($urandom);
            @(posedge clk_sys_i);
            drv_en <= ~d[6:0] | 7'($urandom);
            drv_val <= 7'($urandom);
            wr(8'h0F, d);
            wr(8'hBE, ~d);
            rdc(8'h0F, d & 8'h77);
            rdc(8'hBE, ~d & 8'h77);
            check({1'b0, pd_en}, (d | 8'h08) & 8'h7F);
            rdc(8'h0E, {1'b0, pin_lvl});
        end
        $display("input and pulldown control done");
        wr(8'h0F, 8'h77);
        for (int s = 0; s < 2; s++) begin
            for (int f = 0; f < 8; f++) begin
                p = (f % 6 < 3) ? f % 6 : f % 6 + 1;
                @(posedge clk_sys_i);
                {fwd, lock, pass, fv, lv, pen, fsync} <= 19'($urandom);
                d = {f[2:0], 2'b00, s[0], f[0], 1'b1};
                wr(8'h10 + p[7:0], d);
                settle();
                check({7'h0, pin_out[p]}, {7'h0, exp_out(d)});
                check({7'h0, pin_oe[p]}, 8'h01);
                wr(8'h10 + p[7:0], 8'h00);
            end
        end
        for (int v = 0; v < 2; v++) begin
            d = {6'h04, v[0], 1'b1};
            wr(8'h16, d);
            settle();
            check({7'h0, pin_out[6]}, {7'h0, v[0]});
        end
        // Device status group: lock and pass combinations, frame sync and both interrupt senses.
        for (int f = 1; f < 8; f++) begin
            @(posedge clk_sys_i);
            {lock, pass, pen, fsync, irq} <= 8'($urandom);
            d = {f[2:0], 5'h11};
            wr(8'h10, d);
            settle();
            check({7'h0, pin_out[0]}, {7'h0, exp_dev(d[7:5])});
            check({7'h0, pin_oe[0]}, 8'h01);
            wr(8'h10, 8'h00);
        end
        @(posedge clk_sys_i);
        irq <= 1'b0;
        $display("output functions done");
        wr(8'h13, 8'h11);
        settle();
        check({6'h0, pin_oe[3], pin_out[3]}, 8'h02);
        rdc(8'h0E, {1'b0, pin_lvl[6:4], 1'b0, pin_lvl[2:0]});
        wr(8'h13, 8'h13);
        settle();
        check({7'h0, pin_oe[3]}, 8'h00);
        @(posedge clk_sys_i);
        irq <= 1'b1;
        settle();
        check({6'h0, pin_oe[3], pin_out[3]}, 8'h02);
        $display("open-drain pin done");
        end_sim();
    end
endmodule
bind gpc_pin_control gpc_pin_control_chk #(.PIN_COUNT(PIN_COUNT)) i_gpc_pin_control_chk (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .pin_input_en_o(pin_input_en_o), .pin_pulldown_en_o(pin_pulldown_en_o),
    .rx_fwd_gpio_i(rx_fwd_gpio_i));
`default_nettype wire
